// ===== design/pwm_channel.sv
module pwm_channel #(
  parameter longint STEP_CYCLES = 4000
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [room_pkg::PCT_W-1:0] duty_i,
  input wire logic invert_i,
  output logic pwm_o
);
  import room_pkg::*;

  logic [31:0] pre_reg;
  logic [31:0] pre_next;
  logic [PCT_W-1:0] slot_reg;
  logic [PCT_W-1:0] slot_next;
  logic pwm_reg;
  logic pwm_next;

  // one period is 100 slots; duty counts slots high
  always_comb
  begin
    pre_next = pre_reg;
    slot_next = slot_reg;
    if (pre_reg == 32'(STEP_CYCLES - 1))
    begin
      pre_next = 32'h0;
      slot_next = (slot_reg == PCT_MAX - 7'h01) ? 7'h00 : slot_reg + 7'h01;
    end
    else
    begin
      pre_next = pre_reg + 32'h1;
    end
    pwm_next = (slot_reg < duty_i) ^ invert_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pre_reg <= 32'h0;
      slot_reg <= 7'h00;
      pwm_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pre_reg <= pre_next;
      slot_reg <= slot_next;
      pwm_reg <= pwm_next;
    end
  end

  assign pwm_o = pwm_reg;

endmodule

// ===== design/room_mode_and_output_regs.sv
module room_mode_and_output_regs #(
  parameter longint STEP_CYCLES = room_pkg::RUNDOWN_STEP_CYCLES,
  parameter longint PWM_STEP = room_pkg::PWM_STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire room_pkg::reg_req_t req_i,
  output logic [room_pkg::DATA_W-1:0] rdata_o,
  input wire logic presence_i,
  input wire logic remote_io_selection_i,
  input wire logic [3:0] app_uses_output_i,
  input wire room_pkg::levels_t app_levels_i,
  output room_pkg::eff_mode_t eff_mode_o,
  output logic changeover_cooling_o,
  output logic dew_point_wet_o,
  output logic manual_control_o,
  output logic [room_pkg::PCT_W-1:0] heating_valve_o,
  output logic [room_pkg::PCT_W-1:0] cooling_valve_o,
  output logic [room_pkg::PCT_W-1:0] analog_output_a_o,
  output logic [room_pkg::PCT_W-1:0] analog_output_b_o,
  output logic pwm_output_a_o,
  output logic pwm_output_b_o
);
  import room_pkg::*;

  // software-visible state
  logic [4:0] rundown_reg;
  logic [4:0] rundown_next;
  logic [7:0] ctrl_mode_reg;
  logic [7:0] ctrl_mode_next;
  logic manual_reg;
  logic manual_next;
  logic [7:0] occ_mode_reg;
  logic [7:0] occ_mode_next;
  logic changeover_reg;
  logic changeover_next;
  logic dew_point_reg;
  logic dew_point_next;
  levels_t man_reg;
  levels_t man_next;
  logic [3:0] invert_reg;
  logic [3:0] invert_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // occupancy state
  eff_mode_t eff_reg;
  eff_mode_t eff_next;
  logic [35:0] pre_reg;
  logic [35:0] pre_next;
  logic [4:0] step_reg;
  logic [4:0] step_next;
  logic rundown_live;
  logic step_done;

  // output state
  levels_t out_reg;
  levels_t out_next;

  // per-output steering, indexed in inversion-mask order
  logic [3:0] out_free;
  logic [PCT_W-1:0] man_lvl [4];
  logic [PCT_W-1:0] app_lvl [4];
  logic [PCT_W-1:0] src_lvl [4];

  logic wr_hit;
  logic [PCT_W-1:0] wr_pct;
  logic [4:0] wr_rundown;

  // out-of-range percent writes saturate instead of wrapping
  function automatic logic [PCT_W-1:0] clamp_pct(input logic [DATA_W-1:0] v);
    logic [PCT_W-1:0] r;
    r = (v > 32'(PCT_MAX)) ? PCT_MAX : v[PCT_W-1:0];
    return r;
  endfunction

  function automatic logic [PCT_W-1:0] flip_pct(input logic [PCT_W-1:0] v,
                                               input logic inv);
    logic [PCT_W-1:0] r;
    r = inv ? PCT_MAX - v : v;
    return r;
  endfunction

  function automatic logic [4:0] clamp_rundown(input logic [DATA_W-1:0] v);
    logic [4:0] r;
    r = (v > 32'(RUNDOWN_MAX)) ? RUNDOWN_MAX : v[4:0];
    return r;
  endfunction

  // ---------------- register port ----------------
  always_comb
  begin
    wr_hit = req_i.wr;
    wr_pct = clamp_pct(req_i.wdata);
    wr_rundown = clamp_rundown(req_i.wdata);
    rundown_next = rundown_reg;
    ctrl_mode_next = ctrl_mode_reg;
    occ_mode_next = occ_mode_reg;
    changeover_next = changeover_reg;
    dew_point_next = dew_point_reg;
    man_next = man_reg;
    invert_next = invert_reg;
    // unmapped and read-only offsets fall through, so such writes are dropped
    if (wr_hit)
    begin
      case (req_i.addr)
        OFS_RUNDOWN: rundown_next = wr_rundown;
        OFS_CTRL_MODE: ctrl_mode_next = req_i.wdata[7:0];
        OFS_OCC_MODE: occ_mode_next = req_i.wdata[7:0];
        OFS_CHANGEOVER: changeover_next = req_i.wdata[0];
        OFS_DEW_POINT: dew_point_next = req_i.wdata[0];
        OFS_AO_A: man_next.ao_a = wr_pct;
        OFS_AO_B: man_next.ao_b = wr_pct;
        OFS_PWM_A: man_next.pwm_a = wr_pct;
        OFS_PWM_B: man_next.pwm_b = wr_pct;
        OFS_HEAT_MAN: man_next.heat = wr_pct;
        OFS_COOL_MAN: man_next.cool = wr_pct;
        OFS_INVERT: invert_next = req_i.wdata[3:0];
        default: ;
      endcase
    end
    // kept in a flop so the status pin stays glitch-free
    manual_next = (ctrl_mode_next == CTRL_MANUAL);
  end

  // read data is registered; unmapped offsets read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (req_i.rd)
    begin
      case (req_i.addr)
        OFS_RUNDOWN: rdata_next = {27'h0, rundown_reg};
        OFS_CTRL_MODE: rdata_next = {24'h0, ctrl_mode_reg};
        OFS_OCC_MODE: rdata_next = {24'h0, occ_mode_reg};
        OFS_CHANGEOVER: rdata_next = {31'h0, changeover_reg};
        OFS_DEW_POINT: rdata_next = {31'h0, dew_point_reg};
        OFS_AO_A: rdata_next = {25'h0, man_reg.ao_a};
        OFS_AO_B: rdata_next = {25'h0, man_reg.ao_b};
        OFS_PWM_A: rdata_next = {25'h0, man_reg.pwm_a};
        OFS_PWM_B: rdata_next = {25'h0, man_reg.pwm_b};
        OFS_HEAT_MAN: rdata_next = {25'h0, man_reg.heat};
        OFS_COOL_MAN: rdata_next = {25'h0, man_reg.cool};
        OFS_EFF_MODE: rdata_next = {30'h0, eff_reg};
        OFS_INVERT: rdata_next = {28'h0, invert_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rundown_reg <= RUNDOWN_RST;
      ctrl_mode_reg <= CTRL_MODE_RST;
      manual_reg <= (CTRL_MODE_RST == CTRL_MANUAL);
      occ_mode_reg <= OCC_MODE_RST;
      changeover_reg <= 1'b0;
      dew_point_reg <= 1'b0;
      man_reg <= '0;
      invert_reg <= INVERT_RST;
      rdata_reg <= 32'h0;
    end
    else if (ce_i)
    begin
      rundown_reg <= rundown_next;
      ctrl_mode_reg <= ctrl_mode_next;
      manual_reg <= manual_next;
      occ_mode_reg <= occ_mode_next;
      changeover_reg <= changeover_next;
      dew_point_reg <= dew_point_next;
      man_reg <= man_next;
      invert_reg <= invert_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------- occupancy mode ----------------
  // the run-down timer only runs in the presence-driven reduced mode;
  // it is cleared elsewhere so a stale count cannot hold comfort later
  always_comb
  begin
    pre_next = pre_reg;
    step_next = step_reg;
    eff_next = eff_reg;
    rundown_live = (eff_reg == EFF_COMFORT) && (step_reg != 5'h00);
    step_done = (pre_reg == 36'(STEP_CYCLES - 1));
    unique case (occ_mode_reg)
      OCC_COMFORT_FIXED:
      begin
        pre_next = 36'h0;
        step_next = 5'h00;
        eff_next = EFF_COMFORT;
      end
      OCC_REDUCED_PRESENCE:
      begin
        if (presence_i)
        begin
          pre_next = 36'h0;
          step_next = rundown_reg;
          eff_next = EFF_COMFORT;
        end
        else if (rundown_live)
        begin
          eff_next = EFF_COMFORT;
          if (step_done)
          begin
            pre_next = 36'h0;
            step_next = step_reg - 5'h01;
          end
          else
          begin
            pre_next = pre_reg + 36'h1;
          end
        end
        else
        begin
          pre_next = 36'h0;
          step_next = 5'h00;
          eff_next = EFF_REDUCED;
        end
      end
      OCC_STANDBY_PRESENCE:
      begin
        pre_next = 36'h0;
        step_next = 5'h00;
        eff_next = presence_i ? EFF_COMFORT : EFF_STANDBY;
      end
      OCC_REDUCED_FIXED:
      begin
        pre_next = 36'h0;
        step_next = 5'h00;
        eff_next = EFF_REDUCED;
      end
      default:
      begin
        // undefined codes fall back to comfort, the safe occupied state
        pre_next = 36'h0;
        step_next = 5'h00;
        eff_next = EFF_COMFORT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pre_reg <= 36'h0;
      step_reg <= 5'h00;
      eff_reg <= EFF_COMFORT;
    end
    else if (ce_i)
    begin
      pre_reg <= pre_next;
      step_reg <= step_next;
      eff_reg <= eff_next;
    end
  end

  // ---------------- output steering ----------------
  // slots follow the inversion mask: pwm a, pwm b, analogue a, analogue b
  always_comb
  begin
    man_lvl[INV_PWM_A] = man_reg.pwm_a;
    man_lvl[INV_PWM_B] = man_reg.pwm_b;
    man_lvl[INV_AO_A] = man_reg.ao_a;
    man_lvl[INV_AO_B] = man_reg.ao_b;
    app_lvl[INV_PWM_A] = app_levels_i.pwm_a;
    app_lvl[INV_PWM_B] = app_levels_i.pwm_b;
    app_lvl[INV_AO_A] = app_levels_i.ao_a;
    app_lvl[INV_AO_B] = app_levels_i.ao_b;
  end

  // remote-I/O wins over the application; otherwise a register only
  // reaches an output the application leaves free
  assign out_free = ~app_uses_output_i | {4{remote_io_selection_i}};

  for (genvar k = 0; k < 4; k++)
  begin : g_steer
    assign src_lvl[k] = out_free[k] ? man_lvl[k] : app_lvl[k];
  end

  // analogue inversion mirrors the level; pwm inversion is left to the
  // channel, which complements the waveform instead
  always_comb
  begin
    out_next = out_reg;
    out_next.pwm_a = src_lvl[INV_PWM_A];
    out_next.pwm_b = src_lvl[INV_PWM_B];
    out_next.ao_a = flip_pct(src_lvl[INV_AO_A], invert_reg[INV_AO_A]);
    out_next.ao_b = flip_pct(src_lvl[INV_AO_B], invert_reg[INV_AO_B]);
    if (manual_reg)
    begin
      out_next.heat = man_reg.heat;
      out_next.cool = man_reg.cool;
    end
    else
    begin
      out_next.heat = app_levels_i.heat;
      out_next.cool = app_levels_i.cool;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out_reg <= '0;
    end
    else if (ce_i)
    begin
      out_reg <= out_next;
    end
  end

  pwm_channel #(
    .STEP_CYCLES(PWM_STEP)
  ) u_pwm_a (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .duty_i(out_reg.pwm_a),
    .invert_i(invert_reg[INV_PWM_A]),
    .pwm_o(pwm_output_a_o)
  );

  pwm_channel #(
    .STEP_CYCLES(PWM_STEP)
  ) u_pwm_b (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .duty_i(out_reg.pwm_b),
    .invert_i(invert_reg[INV_PWM_B]),
    .pwm_o(pwm_output_b_o)
  );

  // status and level pins
  assign rdata_o = rdata_reg;
  assign eff_mode_o = eff_reg;
  assign changeover_cooling_o = changeover_reg;
  assign dew_point_wet_o = dew_point_reg;
  assign manual_control_o = manual_reg;
  assign heating_valve_o = out_reg.heat;
  assign cooling_valve_o = out_reg.cool;
  assign analog_output_a_o = out_reg.ao_a;
  assign analog_output_b_o = out_reg.ao_b;

endmodule

// ===== design/room_pkg.sv
// Operation
// - Occupancy mode 0 holds comfort permanently and ignores the presence input.
// - Occupancy mode 1 runs reduced, goes to comfort on presence and returns after the run-down.
// - Occupancy mode 2 gives comfort while presence is seen and standby otherwise.
// - Occupancy mode 5 holds reduced permanently and presence has no effect.
// - A read/write change-over bit selects heating with 0 and cooling with 1.
// - A read/write dew-point bit reads 0 for dry and 1 for condensation.
// - Each analogue output follows its 0 to 100 percent register while the application leaves it free.
// - Each PWM output runs at the 0 to 100 percent duty of its register while the application leaves it free.
// - With remote-I/O selection active every analogue and PWM output is driven from its manual register.
// - In manual control mode the heating valve follows the heating manual level in percent.
// - In manual control mode the cooling valve follows the cooling manual level in percent.
// - Inversion bits 0 to 3 invert PWM a, PWM b, analogue a and analogue b when set.
// - The comfort run-down is set in ten-minute steps from 0 to 24.
// - Writing code 10 to the control mode register selects manual control.
package room_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PCT_W = 7;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_RUNDOWN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_MODE = 8'h1f;
  localparam logic [ADDR_W-1:0] OFS_OCC_MODE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CHANGEOVER = 8'h26;
  localparam logic [ADDR_W-1:0] OFS_DEW_POINT = 8'h27;
  localparam logic [ADDR_W-1:0] OFS_AO_A = 8'h2d;
  localparam logic [ADDR_W-1:0] OFS_AO_B = 8'h2e;
  localparam logic [ADDR_W-1:0] OFS_PWM_A = 8'h2f;
  localparam logic [ADDR_W-1:0] OFS_PWM_B = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_HEAT_MAN = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_COOL_MAN = 8'h39;
  localparam logic [ADDR_W-1:0] OFS_EFF_MODE = 8'h3b;
  localparam logic [ADDR_W-1:0] OFS_INVERT = 8'h90;

  // occupancy mode codes
  localparam logic [7:0] OCC_COMFORT_FIXED = 8'h00;
  localparam logic [7:0] OCC_REDUCED_PRESENCE = 8'h01;
  localparam logic [7:0] OCC_STANDBY_PRESENCE = 8'h02;
  localparam logic [7:0] OCC_REDUCED_FIXED = 8'h05;

  // control mode code for manual valve control
  localparam logic [7:0] CTRL_MANUAL = 8'h0a;

  // inversion mask bit positions
  localparam int INV_PWM_A = 0;
  localparam int INV_PWM_B = 1;
  localparam int INV_AO_A = 2;
  localparam int INV_AO_B = 3;

  // reset values
  localparam logic [7:0] OCC_MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_MODE_RST = 8'h00;
  localparam logic [4:0] RUNDOWN_RST = 5'h00;
  localparam logic [PCT_W-1:0] PCT_RST = 7'h00;
  localparam logic [3:0] INVERT_RST = 4'h0;

  localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;
  localparam logic [4:0] RUNDOWN_MAX = 5'h18;

  // timing
  localparam longint CLK_HZ = 40_000_000;
  localparam longint RUNDOWN_STEP_MIN = 10;
  localparam longint RUNDOWN_STEP_CYCLES = RUNDOWN_STEP_MIN * 60 * CLK_HZ;
  localparam longint PWM_STEP_CYCLES = 4000;

  typedef enum logic [1:0]
  {
    EFF_COMFORT = 2'b00,
    EFF_REDUCED = 2'b01,
    EFF_STANDBY = 2'b10
  } eff_mode_t;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic [PCT_W-1:0] heat;
    logic [PCT_W-1:0] cool;
    logic [PCT_W-1:0] ao_a;
    logic [PCT_W-1:0] ao_b;
    logic [PCT_W-1:0] pwm_a;
    logic [PCT_W-1:0] pwm_b;
  } levels_t;

endpackage

// ===== dv/room_regs_checker.sv
module room_regs_checker
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire room_pkg::reg_req_t req_i,
  input wire logic [room_pkg::DATA_W-1:0] rdata_o,
  input wire logic presence_i,
  input wire room_pkg::eff_mode_t eff_mode_o,
  input wire logic changeover_cooling_o,
  input wire logic dew_point_wet_o,
  input wire logic manual_control_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import room_pkg::*;
  // shadow of the occupancy register, rebuilt from the request stream
  logic [7:0] occ_reg;
  logic [7:0] occ_next;
  always_comb
  begin
    occ_next = occ_reg;
    if (ce_i && req_i.wr && req_i.addr == OFS_OCC_MODE)
      occ_next = req_i.wdata[7:0];
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      occ_reg <= OCC_MODE_RST;
    else
      occ_reg <= occ_next;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_fixed_comfort: assert property (ce_i && occ_reg == OCC_COMFORT_FIXED
    |=> eff_mode_o == EFF_COMFORT) else $error("fixed comfort left");
  chk_presence_wake: assert property (ce_i && occ_reg == OCC_REDUCED_PRESENCE
    && presence_i |=> eff_mode_o == EFF_COMFORT) else $error("presence did not wake");
  chk_standby_idle: assert property (ce_i && occ_reg == OCC_STANDBY_PRESENCE
    && !presence_i |=> eff_mode_o == EFF_STANDBY) else $error("standby not taken");
  chk_fixed_reduced: assert property (ce_i && occ_reg == OCC_REDUCED_FIXED
    |=> eff_mode_o == EFF_REDUCED) else $error("fixed reduced left");
  chk_changeover_bit: assert property (ce_i && req_i.wr && req_i.addr == OFS_CHANGEOVER
    |=> changeover_cooling_o == $past(req_i.wdata[0])) else $error("changeover bit");
  chk_dew_bit: assert property (ce_i && req_i.wr && req_i.addr == OFS_DEW_POINT
    |=> dew_point_wet_o == $past(req_i.wdata[0])) else $error("dew bit");
  chk_manual_code: assert property (ce_i && req_i.wr && req_i.addr == OFS_CTRL_MODE
    |=> manual_control_o == ($past(req_i.wdata[7:0]) == CTRL_MANUAL)) else $error("manual");
  chk_mode_read: assert property (ce_i && req_i.rd && req_i.addr == OFS_EFF_MODE
    |=> rdata_o == 32'($past(eff_mode_o))) else $error("mode read");
  cover property (occ_reg == OCC_REDUCED_PRESENCE && presence_i);
  cover property (eff_mode_o == EFF_STANDBY);
  cover property (manual_control_o);
endmodule

// ===== dv/room_station.sv
module room_station
(
  input wire logic clk_i,
  input wire logic [room_pkg::DATA_W-1:0] rdata_i,
  output room_pkg::reg_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import room_pkg::*;
  initial req_o = '0;
  // request is taken at the edge after it is raised, released just past it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #2;
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    #2;
    req_o = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    #2;
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    #2;
    d = rdata_i;
    req_o = '0;
  endtask
endmodule

// ===== dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import room_pkg::*;
  logic clk, rst_b, ce, presence, remote_io_selection, man, co, dew, pa, pb;
  logic [3:0] uses;
  reg_req_t req;
  levels_t lv;
  eff_mode_t eff;
  logic [31:0] rdata;
  logic [PCT_W-1:0] heat, cool, ao_a, ao_b;
  int num_errors = 0;
  int n_checks = 0;
  room_station host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
  room_mode_and_output_regs #(.STEP_CYCLES(20), .PWM_STEP(2)) dut (.clk_i(clk),
    .rst_b_i(rst_b), .ce_i(ce), .req_i(req), .rdata_o(rdata), .presence_i(presence),
    .remote_io_selection_i(remote_io_selection), .app_uses_output_i(uses), .app_levels_i(lv),
    .eff_mode_o(eff), .changeover_cooling_o(co), .dew_point_wet_o(dew),
    .manual_control_o(man), .heating_valve_o(heat), .cooling_valve_o(cool),
    .analog_output_a_o(ao_a), .analog_output_b_o(ao_b), .pwm_output_a_o(pa),
    .pwm_output_b_o(pb));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(nm, d, exp);
  endtask
  task automatic t_bits();
    host.wr(OFS_CHANGEOVER, 32'h1);
    host.wr(OFS_DEW_POINT, 32'h1);
    cyc(1);
    chk("cool_bit", 32'(co), 32'h1);
    chk("dew_bit", 32'(dew), 32'h1);
    rchk("cool_rd", OFS_CHANGEOVER, 32'h1);
    host.wr(OFS_DEW_POINT, 32'h0);
    rchk("dew_rd", OFS_DEW_POINT, 32'h0);
    host.wr(OFS_EFF_MODE, 32'h2);
    rchk("mode_ro", OFS_EFF_MODE, 32'h0);
    rchk("unmapped", 8'h01, 32'h0);
  endtask
  task automatic t_modes();
    logic [7:0] code [4] = '{OCC_COMFORT_FIXED, OCC_REDUCED_FIXED, OCC_STANDBY_PRESENCE,
      OCC_STANDBY_PRESENCE};
    eff_mode_t exp [4] = '{EFF_COMFORT, EFF_REDUCED, EFF_COMFORT, EFF_STANDBY};
    logic [3:0] pres = 4'b0110;
    for (int i = 0; i < 4; i++)
    begin
      presence = pres[i];
      host.wr(OFS_OCC_MODE, 32'(code[i]));
      cyc(2);
      chk("mode", 32'(eff), 32'(exp[i]));
      rchk("mode_rd", OFS_EFF_MODE, 32'(exp[i]));
    end
    host.wr(OFS_RUNDOWN, 32'd25);
    rchk("rundown_max", OFS_RUNDOWN, 32'd24);
    host.wr(OFS_RUNDOWN, 32'd2);
    presence = 1'b0;
    host.wr(OFS_OCC_MODE, 32'(OCC_REDUCED_PRESENCE));
    cyc(2);
    chk("m1_idle", 32'(eff), 32'(EFF_REDUCED));
    presence = 1'b1;
    cyc(3);
    chk("m1_wake", 32'(eff), 32'(EFF_COMFORT));
    presence = 1'b0;
    // two steps of 20 cycles: still comfort at 30, reduced by 50
    cyc(30);
    chk("m1_hold", 32'(eff), 32'(EFF_COMFORT));
    cyc(20);
    chk("m1_back", 32'(eff), 32'(EFF_REDUCED));
  endtask
  task automatic t_outs();
    lv = '{heat: 7'd11, cool: 7'd12, ao_a: 7'd55, ao_b: 7'd66, pwm_a: 7'd0, pwm_b: 7'd0};
    host.wr(OFS_AO_A, 32'd30);
    host.wr(OFS_AO_B, 32'd100);
    host.wr(OFS_INVERT, 32'h4);
    cyc(2);
    chk("ao_a", 32'(ao_a), 32'd70);
    chk("ao_b", 32'(ao_b), 32'd100);
    uses = 4'b1100;
    cyc(2);
    chk("ao_a_app", 32'(ao_a), 32'd45);
    chk("ao_b_app", 32'(ao_b), 32'd66);
    remote_io_selection = 1'b1;
    cyc(2);
    chk("ao_a_rio", 32'(ao_a), 32'd70);
    chk("ao_b_rio", 32'(ao_b), 32'd100);
  endtask
  task automatic t_manual();
    host.wr(OFS_HEAT_MAN, 32'd40);
    host.wr(OFS_COOL_MAN, 32'd60);
    cyc(2);
    chk("heat_auto", 32'(heat), 32'd11);
    chk("cool_auto", 32'(cool), 32'd12);
    host.wr(OFS_CTRL_MODE, 32'(CTRL_MANUAL));
    cyc(2);
    chk("manual", 32'(man), 32'h1);
    chk("heat_man", 32'(heat), 32'd40);
    chk("cool_man", 32'(cool), 32'd60);
  endtask
  task automatic t_pwm();
    int ha;
    int hb;
    remote_io_selection = 1'b0;
    uses = 4'b0000;
    host.wr(OFS_PWM_A, 32'd25);
    host.wr(OFS_PWM_B, 32'd100);
    host.wr(OFS_INVERT, 32'h1);
    // a new duty takes effect at once, not at the period boundary
    cyc(400);
    ha = 0;
    hb = 0;
    repeat (200)
    begin
      cyc(1);
      ha += int'(pa === 1'b1);
      hb += int'(pb === 1'b1);
    end
    chk("pwm_a", 32'(ha), 32'd150);
    chk("pwm_b", 32'(hb), 32'd200);
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    host.wr(OFS_CHANGEOVER, 32'h0);
    cyc(2);
    chk("ce_hold", 32'(co), 32'h1);
    ce = 1'b1;
    rchk("ce_rd", OFS_CHANGEOVER, 32'h1);
    rst_b = 1'b0;
    cyc(2);
    chk("rst_co", 32'(co), 32'h0);
    chk("rst_man", 32'(man), 32'h0);
    chk("rst_eff", 32'(eff), 32'(EFF_COMFORT));
    rst_b = 1'b1;
    rchk("rst_occ", OFS_OCC_MODE, 32'h0);
  endtask
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    presence = 1'b0;
    remote_io_selection = 1'b0;
    uses = 4'b0000;
    lv = '0;
    repeat (10) @(posedge clk);
    #2;
    rst_b = 1'b1;
    t_bits();
    t_modes();
    t_outs();
    t_manual();
    t_pwm();
    t_freeze();
    conclude();
  end
endmodule
bind room_mode_and_output_regs room_regs_checker chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o), .presence_i(presence_i),
  .eff_mode_o(eff_mode_o), .changeover_cooling_o(changeover_cooling_o),
  .dew_point_wet_o(dew_point_wet_o), .manual_control_o(manual_control_o));
